// File: design/flash_protect_defines.svh
`ifndef FLASH_PROTECT_DEFINES_SVH
`define FLASH_PROTECT_DEFINES_SVH

// register byte addresses
`define SEC_CTRL_ADDR     32'h4004_0500
`define PROT_STATUS_ADDR  32'h4004_0504

// field positions
`define SEC_ENABLE_BIT    0
`define AUTO_OP_BIT       0
`define PROT_LSB          16

// reset values
`define SEC_ENABLE_RESET  1'b1
`define PROT_RESET        6'h00

// keyed rewrite
`define SEC_KEY           32'ha74a9d23
`define SEC_WINDOW_CLKS   16

// timing
`define CLK_MHZ           40
`define RECOVER_TIME_US   2000
`define RECOVER_CYCLES    (`RECOVER_TIME_US * `CLK_MHZ)
`define AUTO_OP_CYCLES    64

`endif

// File: design/flash_protect_pkg.sv
package flash_protect_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP = 2'h0,
        MODE_SINGLE_BOOT = 2'h1,
        MODE_WRITER      = 2'h2,
        MODE_OTHER       = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        CMD_PROT_PROG  = 2'h0,
        CMD_PROT_ERASE = 2'h1,
        CMD_DATA_PROG  = 2'h2,
        CMD_OTHER      = 2'h3
    } cmd_t;

    // gray order along idle -> busy -> locked, failed off the side
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h0,
        ST_BUSY   = 2'h1,
        ST_LOCKED = 2'h3,
        ST_FAILED = 2'h2
    } op_state_t;

endpackage : flash_protect_pkg

// File: design/protect_bit_store.sv
`include "flash_protect_defines.svh"

module protect_bit_store #(
    parameter int NUM_BLOCKS = 6,
    parameter int LOW_GROUP  = 4,
    parameter int BLOCK_W    = 3
) (
    // clock and power-on reset
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // update requests
    input  wire logic                  prog_i,
    input  wire logic                  erase_i,
    input  wire logic [BLOCK_W-1:0]    block_i,
    input  wire logic                  sec_en_i,
    // state
    output logic      [NUM_BLOCKS-1:0] prot_o,
    output logic                       all_prot_o
);
    import flash_protect_pkg::*;

    if (LOW_GROUP < 1 || LOW_GROUP >= NUM_BLOCKS) begin : g_chk
        $error("protect_bit_store: bad group split");
    end

    logic erase_all;
    logic low_sel;

    assign all_prot_o = &prot_o;
    assign erase_all  = erase_i & all_prot_o & ~sec_en_i;
    assign low_sel    = (int'(block_i) < LOW_GROUP);

    // nonvolatile in the real cell; only power-on reset reloads it here
    for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_bit
        localparam bit IN_LOW = (b < LOW_GROUP);
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                prot_o[b] <= 1'b0;
            end else if (erase_all) begin
                prot_o[b] <= 1'b0; // RQ13
            end else if (erase_i && !all_prot_o && (low_sel == IN_LOW)) begin
                prot_o[b] <= 1'b0; // RQ11
            end else if (prog_i && int'(block_i) == b) begin
                prot_o[b] <= 1'b1; // RQ10
            end
        end
    end

    a_prog_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
        prog_i && !erase_i |=> $countones(prot_o ^ $past(prot_o)) <= 1) // RQ10
        else $error("program changed more than one block");

    a_group_erase: assert property (@(posedge clk_i) disable iff (!nrst_i)
        erase_i && !all_prot_o && low_sel
        |=> prot_o[NUM_BLOCKS-1:LOW_GROUP]
            == $past(prot_o[NUM_BLOCKS-1:LOW_GROUP])) // RQ11
        else $error("low group erase touched high group");

    a_erase_all: assert property (@(posedge clk_i) disable iff (!nrst_i)
        erase_i && all_prot_o && !sec_en_i |=> prot_o == '0) // RQ13
        else $error("erase with all protected did not clear all");

endmodule : protect_bit_store

// File: design/security_unlock.sv
`include "flash_protect_defines.svh"

module security_unlock #(
    parameter int WINDOW = `SEC_WINDOW_CLKS
) (
    // clock and resets
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        sys_nrst_i,
    // taken bus accesses
    input  wire logic        acc_i,
    input  wire logic        sec_wr_i,
    input  wire logic        full_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        mode_ok_i,
    // state
    output logic             security_enable_o,
    output logic             armed_o
);
    import flash_protect_pkg::*;

    if (WINDOW < 1 || WINDOW > 31) begin : g_chk
        $error("security_unlock: window out of range");
    end

    localparam logic [4:0] LAST = 5'(WINDOW - 1);

    logic [4:0] cnt;
    logic       key_wr;
    logic       data_wr;

    assign key_wr  = acc_i & sec_wr_i & full_i & (wdata_i == `SEC_KEY);
    assign data_wr = acc_i & sec_wr_i & full_i & armed_o & mode_ok_i; // RQ17

    // reset to one by power-on reset only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            security_enable_o <= `SEC_ENABLE_RESET; // RQ7 RQ8
        end else if (data_wr) begin
            security_enable_o <= wdata_i[`SEC_ENABLE_BIT]; // RQ15 RQ16
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            armed_o <= 1'b0;
            cnt     <= 5'h00;
        end else if (!sys_nrst_i) begin
            armed_o <= 1'b0;
            cnt     <= 5'h00;
        end else if (data_wr) begin
            armed_o <= 1'b0;
        end else if (key_wr) begin
            armed_o <= 1'b1; // RQ20
            cnt     <= 5'h00;
        end else if (armed_o && (acc_i || cnt == LAST)) begin
            armed_o <= 1'b0; // RQ20
        end else if (armed_o) begin
            cnt     <= cnt + 5'h01;
        end
    end

    a_narrow_ignored: assert property (@(posedge clk_i) disable iff (!nrst_i)
        acc_i && sec_wr_i && !full_i |=> $stable(security_enable_o)) // RQ17
        else $error("narrow access changed security enable");

    a_window_expiry: assert property (@(posedge clk_i) disable iff (!nrst_i)
        key_wr && sys_nrst_i ##1 !acc_i [*8] ##1 !acc_i [*8]
        |=> !armed_o) // RQ16
        else $error("unlock window outlived its limit");

    a_no_key_no_change: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        !armed_o |=> $stable(security_enable_o)) // RQ16
        else $error("security enable changed without key");

endmodule : security_unlock

// File: design/flash_protect_security_ctrl.sv
`include "flash_protect_defines.svh"

// Behaviour
// RQ1 - six protect status bits, one means protected
// RQ2 - data program into protected block refused
// RQ3 - host commands only while ready
// RQ4 - command while busy locks until reset
// RQ5 - host holds system reset half microsecond
// RQ6 - reads blocked two ms after lock recovery
// RQ7 - security register reset by power-on only
// RQ8 - security enable resets to one
// RQ9 - protect commands in chip, boot, writer
// RQ10 - protect program sets one block
// RQ11 - erase clears group zero-three or four-five
// RQ12 - host clears security before full erase
// RQ13 - all protected, security off: erase all
// RQ14 - protect bits change by commands only
// RQ15 - security rewrite in chip, boot only
// RQ16 - key then data within sixteen clocks
// RQ17 - key and data need full words
// RQ18 - ready flag low busy, stays low failed
// RQ19 - unused security bits read zero
// RQ20 - other access or timeout drops unlock
module flash_protect_security_ctrl #(
    parameter int NUM_BLOCKS     = 6,
    parameter int LOW_GROUP      = 4,
    parameter int BLOCK_W        = 3,
    parameter int AUTO_OP_CYCLES = `AUTO_OP_CYCLES,
    parameter int RECOVER_CYCLES = `RECOVER_CYCLES
) (
    // clock and resets
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      sys_nrst_i,
    // avalon-mm slave
    input  wire logic [31:0]               avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic      [31:0]               avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // flash command port
    input  wire flash_protect_pkg::mode_t  mode_i,
    input  wire logic                      cmd_valid_i,
    input  wire flash_protect_pkg::cmd_t   cmd_i,
    input  wire logic [BLOCK_W-1:0]        cmd_block_i,
    input  wire logic                      op_fail_i,
    output logic                           cmd_accept_o,
    output logic                           cmd_refuse_o,
    // status
    output logic                           auto_op_flag_o,
    output logic      [NUM_BLOCKS-1:0]     block_protect_status_o,
    output logic                           security_enable_o,
    output logic                           read_enable_o
);
    import flash_protect_pkg::*;

    if (NUM_BLOCKS < 2 || NUM_BLOCKS > 16 || (1 << BLOCK_W) < NUM_BLOCKS)
    begin : g_chk_blocks
        $error("flash_protect_security_ctrl: bad block count");
    end
    if (AUTO_OP_CYCLES < 1 || RECOVER_CYCLES < 1) begin : g_chk_times
        $error("flash_protect_security_ctrl: bad cycle count");
    end

    localparam int AW = $clog2(AUTO_OP_CYCLES + 1);
    localparam int RW = $clog2(RECOVER_CYCLES + 1);
    localparam logic [AW-1:0] AUTO_LOAD = AW'(AUTO_OP_CYCLES);
    localparam logic [RW-1:0] REC_LOAD  = RW'(RECOVER_CYCLES);

    op_state_t       state;
    op_state_t       next_state;
    logic [AW-1:0]   op_cnt;
    logic [RW-1:0]   rec_cnt;
    logic            ack;
    logic            req;
    logic            take;
    logic            sel_sec;
    logic            sel_stat;
    logic            full_word;
    logic            prot_mode_ok;
    logic            sec_mode_ok;
    logic            block_ok;
    logic            block_prot;
    logic            all_prot;
    logic            accept;
    logic            refuse;
    logic            prog_pulse;
    logic            erase_pulse;
    logic            armed;

    // ---------------- bus slave ----------------
    // one wait cycle: every access is taken on its second edge
    assign req       = avs_read_i | avs_write_i;
    assign take      = req & ack;
    assign sel_sec   = (avs_address_i == `SEC_CTRL_ADDR);
    assign sel_stat  = (avs_address_i == `PROT_STATUS_ADDR);
    assign full_word = (avs_byteenable_i == 4'hf);

    assign avs_waitrequest_o = req & ~ack;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= 32'h0000_0000;
            if (sel_sec) begin
                avs_readdata_o[`SEC_ENABLE_BIT] <= security_enable_o; // RQ19
            end else if (sel_stat) begin
                avs_readdata_o[`PROT_LSB +: NUM_BLOCKS] <=
                    block_protect_status_o; // RQ1
                avs_readdata_o[`AUTO_OP_BIT] <= auto_op_flag_o; // RQ18
            end
        end
    end

    // writes to the status word are dropped: protection moves only by
    // command, so a stray store cannot unprotect a block
    security_unlock #(
        .WINDOW            (`SEC_WINDOW_CLKS)
    ) u_unlock (
        .clk_i             (clk_i),
        .nrst_i            (nrst_i),
        .sys_nrst_i        (sys_nrst_i),
        .acc_i             (take),
        .sec_wr_i          (avs_write_i & sel_sec),
        .full_i            (full_word),
        .wdata_i           (avs_writedata_i),
        .mode_ok_i         (sec_mode_ok),
        .security_enable_o (security_enable_o),
        .armed_o           (armed)
    );

    // ---------------- command decode ----------------
    assign prot_mode_ok = (mode_i != MODE_OTHER); // RQ9
    assign sec_mode_ok  = (mode_i == MODE_SINGLE_CHIP) ||
                          (mode_i == MODE_SINGLE_BOOT); // RQ15
    assign block_ok     = (int'(cmd_block_i) < NUM_BLOCKS);
    assign block_prot   = block_ok &&
                          block_protect_status_o[cmd_block_i];

    always_comb begin
        accept = 1'b0;
        refuse = 1'b0;
        if (cmd_valid_i && state == ST_IDLE && sys_nrst_i) begin
            case (cmd_i)
                CMD_PROT_PROG: begin
                    accept = prot_mode_ok && block_ok;
                end
                CMD_PROT_ERASE: begin
                    // full erase is refused until security is cleared first
                    accept = prot_mode_ok && block_ok &&
                             !(all_prot && security_enable_o); // RQ13
                end
                CMD_DATA_PROG: begin
                    accept = block_ok && !block_prot; // RQ2
                end
                default: begin
                    accept = 1'b1;
                end
            endcase
            refuse = !accept;
        end
    end

    assign prog_pulse  = accept && cmd_i == CMD_PROT_PROG; // RQ14
    assign erase_pulse = accept && cmd_i == CMD_PROT_ERASE; // RQ14

    protect_bit_store #(
        .NUM_BLOCKS (NUM_BLOCKS),
        .LOW_GROUP  (LOW_GROUP),
        .BLOCK_W    (BLOCK_W)
    ) u_store (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .prog_i     (prog_pulse),
        .erase_i    (erase_pulse),
        .block_i    (cmd_block_i),
        .sec_en_i   (security_enable_o),
        .prot_o     (block_protect_status_o),
        .all_prot_o (all_prot)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_accept_o <= 1'b0;
            cmd_refuse_o <= 1'b0;
        end else begin
            cmd_accept_o <= accept;
            cmd_refuse_o <= refuse;
        end
    end

    // ---------------- automatic operation ----------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cmd_valid_i) begin
                    next_state = ST_LOCKED; // RQ4
                end else if (op_fail_i) begin
                    next_state = ST_FAILED; // RQ18
                end else if (op_cnt == '0) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FAILED: begin
                if (cmd_valid_i) begin
                    next_state = ST_LOCKED; // RQ4
                end
            end
            ST_LOCKED: begin
                next_state = ST_LOCKED; // RQ4
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // system reset is synchronous so a glitch cannot half-clear the state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
        end else if (!sys_nrst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_cnt <= '0;
        end else if (accept) begin
            op_cnt <= AUTO_LOAD - AW'(1);
        end else if (state == ST_BUSY && op_cnt != '0) begin
            op_cnt <= op_cnt - AW'(1);
        end
    end

    assign auto_op_flag_o = (state == ST_IDLE); // RQ18

    // ---------------- read recovery after lockout ----------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rec_cnt <= '0;
        end else if (!sys_nrst_i && (state == ST_LOCKED || rec_cnt != '0))
        begin
            rec_cnt <= REC_LOAD; // RQ6
        end else if (sys_nrst_i && rec_cnt != '0) begin
            rec_cnt <= rec_cnt - RW'(1); // RQ6
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            read_enable_o <= 1'b1;
        end else begin
            read_enable_o <= sys_nrst_i && (rec_cnt == '0 ||
                             rec_cnt == RW'(1)); // RQ6
        end
    end

    // ---------------- checks ----------------
    a_refuse_protected: assert property (@(posedge clk_i)
        disable iff (!nrst_i)
        cmd_valid_i && cmd_i == CMD_DATA_PROG && block_prot &&
        state == ST_IDLE && sys_nrst_i |=> cmd_refuse_o && !cmd_accept_o)
        else $error("data program into protected block accepted"); // RQ2

    a_lock_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ST_LOCKED && sys_nrst_i |=> state == ST_LOCKED) // RQ4
        else $error("lock left without system reset");

    a_busy_lock: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ST_BUSY && cmd_valid_i && sys_nrst_i
        |=> !auto_op_flag_o [*3]) // RQ4
        else $error("command while busy did not lock");

    a_read_hold: assert property (@(posedge clk_i) // RQ6
        disable iff (!nrst_i)
        $rose(sys_nrst_i) && rec_cnt != '0
        |-> !read_enable_o [*8])
        else $error("reads enabled too soon after lock recovery");

    a_failed_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
        state == ST_FAILED && sys_nrst_i && !cmd_valid_i
        |=> !auto_op_flag_o && state == ST_FAILED) // RQ18
        else $error("ready flag rose after failed operation");

    a_mode_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cmd_valid_i && mode_i == MODE_OTHER && cmd_i != CMD_OTHER &&
        cmd_i != CMD_DATA_PROG |=> !cmd_accept_o &&
        $stable(block_protect_status_o)) // RQ9
        else $error("protect command accepted in wrong mode");

    a_status_ro: assert property (@(posedge clk_i) disable iff (!nrst_i)
        take && avs_write_i && !cmd_valid_i
        |=> $stable(block_protect_status_o)) // RQ14
        else $error("register write changed protection");

    a_sec_unused: assert property (@(posedge clk_i) disable iff (!nrst_i)
        avs_read_i && !ack && sel_sec
        |=> avs_readdata_o[31:1] == 31'h0000_0000 &&
            avs_readdata_o[0] == $past(security_enable_o)) // RQ19
        else $error("security read shows wrong bits");

    a_sec_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_i == MODE_WRITER |=> $stable(security_enable_o)) // RQ15
        else $error("security rewritten in writer mode");

endmodule : flash_protect_security_ctrl

// File: test/flash_host_model.sv
module flash_host_model (
    // clock and status
    input  wire logic                    clk_i,
    input  wire logic                    ready_i,
    // command port and system reset
    output logic                         cmd_valid_o,
    output flash_protect_pkg::cmd_t      cmd_o,
    output logic [2:0]                   cmd_block_o,
    output logic                         sys_nrst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import flash_protect_pkg::*;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = CMD_OTHER;
        cmd_block_o = 3'h0;
        sys_nrst_o = 1'b1;
    end

    // a polite host waits for ready; an impolite one issues at once, which locks the device if busy
    task automatic issue(input cmd_t c, input logic [2:0] b,
                         input bit polite, output bit ok);
        ok = 1'b1;
        @(posedge clk_i);
        if (polite) begin
            ok = 1'b0;
            for (int i = 0; i < 200 && !ok; i++) begin
                if (ready_i === 1'b1) ok = 1'b1;
                else @(posedge clk_i);
            end
        end
        if (!ok) return;
        cmd_valid_o <= 1'b1;
        cmd_o <= c;
        cmd_block_o <= b;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
    endtask : issue

    // 20 cycles at 40 MHz covers the half microsecond
    task automatic sys_reset();
        @(posedge clk_i);
        sys_nrst_o <= 1'b0;
        repeat (20) @(posedge clk_i);
        sys_nrst_o <= 1'b1;
    endtask : sys_reset
endmodule : flash_host_model

// File: test/flash_protect_security_ctrl_tb_top.sv
`include "flash_protect_defines.svh"

module flash_protect_security_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_protect_pkg::*;

    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [31:0] avs_address = 32'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    mode_t       mode = MODE_SINGLE_CHIP;
    logic        op_fail = 1'b0;
    logic        cmd_valid, sys_nrst, acc, refu, flag, sec_en, rd_en;
    cmd_t        cmd;
    logic [2:0]  cmd_block;
    logic [5:0]  prot;
    int          err_total = 0;
    int          num_checks = 0;
    int          cnt;
    logic [2:0]  pb [3] = '{3'h0, 3'h4, 3'h5};

    always #12.5 clk_i = ~clk_i;

    flash_protect_security_ctrl #(
        .AUTO_OP_CYCLES(8),
        .RECOVER_CYCLES(50)
    ) u_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .sys_nrst_i(sys_nrst),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .mode_i(mode),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_block_i(cmd_block),
        .op_fail_i(op_fail), .cmd_accept_o(acc), .cmd_refuse_o(refu),
        .auto_op_flag_o(flag), .block_protect_status_o(prot),
        .security_enable_o(sec_en), .read_enable_o(rd_en)
    );

    flash_host_model u_host (
        .clk_i(clk_i), .ready_i(flag), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd), .cmd_block_o(cmd_block), .sys_nrst_o(sys_nrst)
    );

    task automatic finish_test();
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask : chk

    task automatic hang(input string n);
        chk(n, 32'h0, 32'h1);
        finish_test();
    endtask : hang

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        bit done;
        done = 1'b0;
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge clk_i);
            done = (avs_waitrequest === 1'b0);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (!done) hang("waitrequest");
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr

    task automatic rd(input string n, input logic [31:0] a,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(n, q, exp);
    endtask : rd

    function automatic logic [31:0] st(input logic [5:0] p);
        return {10'h0, p, 16'h1};
    endfunction : st

    // key, idle gap, then data; gap 13 is the last one honoured
    task automatic sec_wr(input int gap, input logic [31:0] d,
                          input logic [3:0] be, input logic exp);
        wr(`SEC_CTRL_ADDR, `SEC_KEY, 4'hf);
        repeat (gap) @(posedge clk_i);
        wr(`SEC_CTRL_ADDR, d, be);
        rd("security", `SEC_CTRL_ADDR, {31'h0, exp});
    endtask : sec_wr

    task automatic wait_ready();
        for (int i = 0; i < 100; i++) begin
            @(posedge clk_i);
            if (flag === 1'b1) return;
        end
        hang("ready");
    endtask : wait_ready

    task automatic do_cmd(input cmd_t c, input logic [2:0] b,
                          input bit pol, input logic [1:0] exp);
        bit ok;
        u_host.issue(c, b, pol, ok);
        if (!ok) hang("ready");
        #1;
        chk("answer", {30'h0, acc, refu}, {30'h0, exp});
        if (exp == 2'b10) chk("busy", flag, 1'b0);
        if (exp == 2'b10 && pol) wait_ready();
    endtask : do_cmd

    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        rd("status", `PROT_STATUS_ADDR, st(6'h00));
        rd("unmapped", 32'h4004_0508, 32'h0);
        wr(`PROT_STATUS_ADDR, 32'hffff_ffff, 4'hf);
        rd("status", `PROT_STATUS_ADDR, st(6'h00));
        wr(`SEC_CTRL_ADDR, 32'h0, 4'hf);
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        do_cmd(CMD_PROT_PROG, 3'h2, 1'b1, 2'b10);
        rd("status", `PROT_STATUS_ADDR, st(6'h04));
        do_cmd(CMD_DATA_PROG, 3'h2, 1'b1, 2'b01);
        do_cmd(CMD_DATA_PROG, 3'h1, 1'b1, 2'b10);
        do_cmd(CMD_PROT_PROG, 3'h6, 1'b1, 2'b01);
        do_cmd(CMD_OTHER, 3'h0, 1'b1, 2'b10);
        mode <= MODE_OTHER;
        do_cmd(CMD_PROT_PROG, 3'h4, 1'b1, 2'b01);
        for (int b = 0; b < 6; b++) begin
            mode <= mode_t'(b % 3);
            do_cmd(CMD_PROT_PROG, 3'(b), 1'b1, 2'b10);
        end
        mode <= MODE_SINGLE_CHIP;
        rd("status", `PROT_STATUS_ADDR, st(6'h3f));
        do_cmd(CMD_PROT_ERASE, 3'h0, 1'b1, 2'b01);
        sec_wr(0, 32'h0, 4'hf, 1'b0);
        do_cmd(CMD_PROT_ERASE, 3'h0, 1'b1, 2'b10);
        rd("status", `PROT_STATUS_ADDR, st(6'h00));
        foreach (pb[i]) do_cmd(CMD_PROT_PROG, pb[i], 1'b1, 2'b10);
        do_cmd(CMD_PROT_ERASE, 3'h5, 1'b1, 2'b10);
        rd("status", `PROT_STATUS_ADDR, st(6'h01));
        do_cmd(CMD_PROT_ERASE, 3'h1, 1'b1, 2'b10);
        rd("status", `PROT_STATUS_ADDR, st(6'h00));
        sec_wr(13, 32'h1, 4'hf, 1'b1);
        sec_wr(14, 32'h0, 4'hf, 1'b1);
        sec_wr(0, 32'h0, 4'h1, 1'b1);
        wr(`SEC_CTRL_ADDR, `SEC_KEY, 4'h3);
        wr(`SEC_CTRL_ADDR, 32'h0, 4'hf);
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        wr(`SEC_CTRL_ADDR, `SEC_KEY, 4'hf);
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        wr(`SEC_CTRL_ADDR, 32'h0, 4'hf);
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        mode <= MODE_WRITER;
        sec_wr(0, 32'h0, 4'hf, 1'b1);
        mode <= MODE_SINGLE_BOOT;
        sec_wr(0, 32'hffff_fffe, 4'hf, 1'b0);
        chk("security pin", sec_en, 1'b0);
        mode <= MODE_SINGLE_CHIP;
        do_cmd(CMD_PROT_PROG, 3'h3, 1'b0, 2'b10);
        do_cmd(CMD_PROT_PROG, 3'h1, 1'b0, 2'b00);
        repeat (12) @(posedge clk_i);
        chk("locked", flag, 1'b0);
        u_host.sys_reset();
        @(posedge clk_i);
        #1;
        chk("read hold", rd_en, 1'b0);
        for (cnt = 0; cnt < 200 && rd_en !== 1'b1; cnt++)
            @(posedge clk_i);
        chk("hold length", 32'(cnt >= 25 && cnt <= 55), 32'h1);
        chk("unlocked", flag, 1'b1);
        rd("security", `SEC_CTRL_ADDR, 32'h0);
        rd("status", `PROT_STATUS_ADDR, st(6'h08));
        chk("protect pin", prot, 6'h08);
        do_cmd(CMD_DATA_PROG, 3'h0, 1'b0, 2'b10);
        op_fail <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk("failed", flag, 1'b0);
        op_fail <= 1'b0;
        u_host.sys_reset();
        @(posedge clk_i);
        #1;
        chk("recovered", flag, 1'b1);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        nrst_i <= 1'b1;
        rd("security", `SEC_CTRL_ADDR, 32'h1);
        rd("status", `PROT_STATUS_ADDR, st(6'h00));
        finish_test();
    end
endmodule : flash_protect_security_ctrl_tb_top
